// *** shared/rwc_pkg.sv ***
// constants, types and register layout of the reset and watchdog controller
// Contract
// R01: any reset loads the reset vector pair and sets the interrupt mask.
// R02: power-on drives the pin low for a 16 or 4064 cycle delay.
// R03: pin still low after the startup delay keeps the chip in reset.
// R04: power-on flag set only by power-on; writing zero clears it.
// R05: every reset returns the watchdog enable bit to its option value.
// R06: outside agent holds the pin low 1.5 machine cycles for a reset.
// R07: on pin release the device resumes on the next machine cycle.
// R08: power-on and watchdog resets pull the pin low, open drain.
// R09: watchdog clock: timer bit 7 carry, divide 4, 256, then 7.
// R10: watchdog enabled by option or writing one; zero does nothing.
// R11: each write of one to the enable bit clears the divide-by-7.
// R12: chip reset seven counter clocks after clear or enable.
// R13: software clears the watchdog within its timeout period.
// R14: watchdog reset releases the pin after seeing it low for hold time.
// R15: stop with watchdog enabled gives a watchdog reset, no startup delay.
// R16: option: watchdog counts in wait, or clears and halts until exit.
// R17: external and power-on resets reset timer, direction regs, stack, irq enable.
// R18: external and power-on resets clear stop, irq, wait latches, restart bus.
// R19: external and power-on resets disable serial port, set its transmit flags.
// R20: wait or stop entry clears the interrupt mask; resets do not.
// R21: power-on and stop hold oscillator off 4064 cycles, clear timer/serial clocks.
// R22: external, power-on, stop disable converter, clear slow mode, reset enable bits.
// R23: watchdog counter reset by external reset, power-on, wait and stop.
// R24: pin input is synchronised before it is measured or acted on.
// R25: overlapping resets hold reset until all are gone, then leave at once.
package rwc_pkg;
   // ======================================================
   // register map
   localparam int ADDR_W = 8;
   localparam logic [7:0] MISC_OFS = 8'h0C;
   localparam int BIT_POR = 7;
   localparam int BIT_IRQ_POS = 6;
   localparam int BIT_IRQ_NEG = 5;
   localparam int BIT_IRQ_EN = 4;
   localparam int BIT_OPT_A = 3;
   localparam int BIT_OPT_B = 2;
   localparam int BIT_SLOW = 1;
   localparam int BIT_WD = 0;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // ======================================================
   // values the core loads
   localparam logic [15:0] RESET_VECTOR = 16'h3FFE;
   localparam logic [15:0] TIMER_PRESET = 16'hFFFC;
   localparam logic [15:0] STACK_INIT = 16'h00FF;
   // ======================================================
   // timing
   localparam int CLK_MHZ = 20;
   localparam int MACHINE_CYCLE_NS = 50;
   localparam int EXT_LOW_MIN_X10 = 15;
   localparam int EXT_LOW_CYC_I = (EXT_LOW_MIN_X10 * MACHINE_CYCLE_NS * CLK_MHZ + 9999) / 10000;
   localparam logic [11:0] EXT_LOW_CYC = 12'(EXT_LOW_CYC_I < 1 ? 1 : EXT_LOW_CYC_I);
   localparam logic [11:0] STARTUP_SHORT = 12'h010;
   localparam logic [11:0] STARTUP_LONG_CYC = 12'hFE0;
   localparam logic [11:0] OSC_OFF_CYC = 12'hFE0;
   // ======================================================
   // watchdog chain
   localparam int PRE_DIV = 4 * 256;
   localparam int PRE_W = $clog2(PRE_DIV);
   localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(PRE_DIV - 1);
   localparam logic [2:0] WD_FINAL = 3'h7;
   // ======================================================
   // sequencer states
   typedef enum logic [2:0] {
      ST_OSC, ST_POR, ST_PINWAIT, ST_WDHOLD, ST_WDREL, ST_RUN, ST_STOP
   } rwc_state_e;
endpackage

// *** shared/rwc_wd_if.sv ***
// control bundle between sequencer and watchdog counter
`timescale 1ns/1ps
interface rwc_wd_if;
   logic carry;
   logic enable;
   logic clear;
   logic halt;
   logic timeout;
   modport ctl (output carry, output enable, output clear, output halt, input timeout);
   modport core (input carry, input enable, input clear, input halt, output timeout);
endinterface

// *** design/rwc_sync.sv ***
// two flip-flop synchroniser for the reset pin level
`timescale 1ns/1ps
module rwc_sync (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic d,
   output logic q
);
   import rwc_pkg::*;
   logic meta_reg;
   // pin idles high, so both stages reset high
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         meta_reg <= 1'b1;
         q <= 1'b1;
      end else begin
         meta_reg <= d; // [R24]
         q <= meta_reg;
      end
   end
endmodule

// *** design/rwc_watchdog_enable_bit.sv ***
// watchdog prescaler and divide-by-7 counter
`timescale 1ns/1ps
module rwc_wdt (
   input wire logic aclk,
   input wire logic aresetn,
   rwc_wd_if.core wd
);
   import rwc_pkg::*;
   logic [PRE_W-1:0] pre_reg;
   logic [2:0] div_reg;
   logic tick;
   logic hit;
   logic timeout_reg;
   // ======================================================
   // prescaler: divide 4 then divide 256, as one counter
   assign tick = wd.carry && (pre_reg == PRE_LAST); // [R09]
   assign hit = tick && wd.enable && !wd.halt && (div_reg == WD_FINAL - 3'h1);
   assign wd.timeout = timeout_reg;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pre_reg <= '0;
      end else if (wd.carry) begin
         pre_reg <= pre_reg + 1'b1;
      end
   end
   // ======================================================
   // divide-by-7: seventh tick after clear is final
   always_ff @(posedge aclk) begin
      if (!aresetn || wd.clear) begin
         div_reg <= 3'h0; // [R11] [R23]
         timeout_reg <= 1'b0;
      end else begin
         timeout_reg <= hit; // [R12]
         if (hit) begin
            div_reg <= 3'h0;
         end else if (tick && wd.enable && !wd.halt) begin // [R16]
            div_reg <= div_reg + 3'h1;
         end
      end
   end
endmodule

// *** design/rwc_top.sv ***
// reset sequencer, pin driver, misc register and bus slave
//
// Decided for this implementation: the AXI4-Lite slave port.
`timescale 1ns/1ps
module rwc_top #(
   parameter bit STARTUP_LONG = 1'b1,
   parameter bit WD_OPTION = 1'b0,
   parameter bit WAIT_HALT = 1'b0,
   parameter logic [11:0] HOLD_CYC = 12'h008
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [rwc_pkg::ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [rwc_pkg::ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic reset_pin_i,
   output logic reset_pin_o,
   output logic reset_pin_oe,
   input wire logic timer_carry7,
   input wire logic cpu_imask,
   input wire logic wait_mode,
   input wire logic stop_exec,
   input wire logic stop_wake,
   output logic cpu_reset,
   output logic periph_reset,
   output logic reset_exit,
   output logic [15:0] reset_vector,
   output logic [15:0] timer_preset,
   output logic [15:0] stack_init,
   output logic imask_clear,
   output logic osc_off,
   output logic conv_nvm_reset,
   output logic [7:0] misc_ctrl
);
   import rwc_pkg::*;

   // ======================================================
   // declarations
   rwc_state_e state_reg, state_next;
   logic [11:0] cnt_reg, cnt_next;
   logic por_seq_reg, por_seq_next;
   logic [7:0] misc_reg, misc_next;
   logic wait_prev_reg;
   logic pin_high;
   logic [11:0] startup_cyc;
   logic in_reset_now, in_reset_next;
   logic ext_por_next;
   logic wait_entry, stop_entry;
   logic wd_set;
   logic aw_full_reg, aw_full_next, w_full_reg, w_full_next;
   logic [ADDR_W-1:0] awaddr_reg;
   logic [7:0] wdata_reg;
   logic wstrb0_reg;
   logic aw_hs, w_hs, ar_hs, wr_fire, wr_hit, rd_hit, misc_write;
   logic rvalid_next;
   rwc_wd_if wd ();

   // ======================================================
   // sub-blocks
   rwc_sync u_sync (
      .aclk(aclk),
      .aresetn(aresetn),
      .d(reset_pin_i),
      .q(pin_high)
   );

   rwc_wdt u_wdt (
      .aclk(aclk),
      .aresetn(aresetn),
      .wd(wd)
   );

   // ======================================================
   // decode
   assign startup_cyc = STARTUP_LONG ? STARTUP_LONG_CYC : STARTUP_SHORT; // [R02]
   assign wait_entry = wait_mode && !wait_prev_reg && (state_reg == ST_RUN);
   assign stop_entry = (state_reg == ST_RUN) && (state_next == ST_STOP);
   assign in_reset_now = (state_reg == ST_POR) || (state_reg == ST_PINWAIT) || (state_reg == ST_WDHOLD)
      || (state_reg == ST_WDREL) || ((state_reg == ST_OSC) && por_seq_reg);
   assign in_reset_next = (state_next == ST_POR) || (state_next == ST_PINWAIT) || (state_next == ST_WDHOLD)
      || (state_next == ST_WDREL) || ((state_next == ST_OSC) && por_seq_next);
   assign ext_por_next = (state_next == ST_POR) || (state_next == ST_PINWAIT)
      || ((state_next == ST_OSC) && por_seq_next);

   // ======================================================
   // reset sequencer
   always_comb begin
      state_next = state_reg;
      cnt_next = cnt_reg + 12'h001;
      por_seq_next = por_seq_reg;
      case (state_reg)
         ST_OSC: begin
            // oscillator off after power-on and stop
            if (cnt_reg == OSC_OFF_CYC - 12'h001) begin // [R21]
               cnt_next = 12'h000;
               state_next = por_seq_reg ? ST_POR : ST_RUN;
            end
         end
         ST_POR: begin
            if (cnt_reg == startup_cyc - 12'h001) begin // [R02]
               cnt_next = 12'h000;
               state_next = ST_PINWAIT;
            end
         end
         ST_PINWAIT: begin
            // outside low extends the reset
            cnt_next = 12'h000;
            por_seq_next = 1'b0;
            if (pin_high) begin
               state_next = ST_RUN; // [R03] [R07] [R25]
            end
         end
         ST_WDHOLD: begin
            // count only while the pin reads low
            if (pin_high) begin
               cnt_next = 12'h000;
            end else if (cnt_reg == HOLD_CYC - 12'h001) begin // [R14]
               cnt_next = 12'h000;
               state_next = ST_WDREL;
            end
         end
         ST_WDREL: begin
            // pin released; wait for it to rise
            cnt_next = 12'h000;
            if (pin_high) begin
               state_next = ST_RUN; // [R25]
            end
         end
         ST_RUN: begin
            if (pin_high) begin
               cnt_next = 12'h000;
            end
            if (!pin_high && (cnt_reg == EXT_LOW_CYC - 12'h001)) begin // [R06]
               cnt_next = 12'h000;
               state_next = ST_PINWAIT;
            end else if (wd.timeout || (stop_exec && misc_reg[BIT_WD])) begin // [R15]
               cnt_next = 12'h000;
               state_next = ST_WDHOLD;
            end else if (stop_exec) begin
               cnt_next = 12'h000;
               state_next = ST_STOP;
            end
         end
         ST_STOP: begin
            cnt_next = 12'h000;
            if (!pin_high) begin
               state_next = ST_PINWAIT;
            end else if (stop_wake) begin
               state_next = ST_OSC; // [R21]
            end
         end
         default: begin
            cnt_next = 12'h000;
            state_next = ST_RUN;
         end
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_reg <= ST_OSC;
         cnt_reg <= 12'h000;
         por_seq_reg <= 1'b1;
         wait_prev_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         cnt_reg <= cnt_next;
         por_seq_reg <= por_seq_next;
         wait_prev_reg <= wait_mode;
      end
   end

   // ======================================================
   // watchdog control
   assign wd_set = misc_write && s_axi_wdata_bit0();
   assign wd.carry = timer_carry7; // [R09]
   assign wd.enable = misc_reg[BIT_WD] && (state_reg == ST_RUN);
   assign wd.clear = in_reset_now || (state_reg == ST_STOP) || (state_reg == ST_OSC)
      || wait_entry || wd_set; // [R11] [R23]
   assign wd.halt = WAIT_HALT && wait_mode; // [R16]

   function automatic logic s_axi_wdata_bit0();
      s_axi_wdata_bit0 = wdata_reg[BIT_WD];
   endfunction

   // ======================================================
   // misc control register
   always_comb begin
      misc_next = misc_reg;
      if (misc_write) begin
         if (!wdata_reg[BIT_POR]) begin
            misc_next[BIT_POR] = 1'b0; // [R04]
         end
         if (cpu_imask) begin
            // irq options writable only while masked
            misc_next[BIT_IRQ_POS] = wdata_reg[BIT_IRQ_POS];
            misc_next[BIT_IRQ_NEG] = wdata_reg[BIT_IRQ_NEG];
            misc_next[BIT_IRQ_EN] = wdata_reg[BIT_IRQ_EN];
         end
         misc_next[BIT_OPT_A] = wdata_reg[BIT_OPT_A];
         misc_next[BIT_OPT_B] = wdata_reg[BIT_OPT_B];
         misc_next[BIT_SLOW] = wdata_reg[BIT_SLOW];
         if (wdata_reg[BIT_WD]) begin
            misc_next[BIT_WD] = 1'b1; // [R10]
         end
      end
      if (ext_por_next) begin
         misc_next[BIT_IRQ_POS] = 1'b0;
         misc_next[BIT_IRQ_NEG] = 1'b0;
         misc_next[BIT_IRQ_EN] = 1'b1; // [R17]
         misc_next[BIT_OPT_A] = 1'b0;
         misc_next[BIT_OPT_B] = 1'b0;
      end
      if (ext_por_next || stop_entry) begin
         misc_next[BIT_SLOW] = 1'b0; // [R22]
      end
      if (in_reset_next || stop_entry) begin
         misc_next[BIT_WD] = WD_OPTION; // [R05] [R22]
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         // power-on: flag set here and nowhere else
         misc_reg <= {1'b1, 3'h1, 3'h0, WD_OPTION}; // [R04] [R05]
      end else begin
         misc_reg <= misc_next;
      end
   end

   // ======================================================
   // bus slave, write side: address and data taken in either order
   assign aw_hs = s_axi_awvalid && s_axi_awready;
   assign w_hs = s_axi_wvalid && s_axi_wready;
   assign wr_fire = aw_full_reg && w_full_reg && !s_axi_bvalid;
   assign wr_hit = awaddr_reg[ADDR_W-1:2] == MISC_OFS[ADDR_W-1:2];
   assign misc_write = wr_fire && wr_hit && wstrb0_reg;
   assign aw_full_next = (aw_full_reg && !wr_fire) || aw_hs;
   assign w_full_next = (w_full_reg && !wr_fire) || w_hs;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_full_reg <= 1'b0;
         w_full_reg <= 1'b0;
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
         awaddr_reg <= '0;
         wdata_reg <= 8'h00;
         wstrb0_reg <= 1'b0;
      end else begin
         aw_full_reg <= aw_full_next;
         w_full_reg <= w_full_next;
         s_axi_awready <= !aw_full_next;
         s_axi_wready <= !w_full_next;
         if (aw_hs) begin
            awaddr_reg <= s_axi_awaddr;
         end
         if (w_hs) begin
            wdata_reg <= s_axi_wdata[7:0];
            wstrb0_reg <= s_axi_wstrb[0];
         end
         if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // ======================================================
   // bus slave, read side: one read outstanding
   assign ar_hs = s_axi_arvalid && s_axi_arready;
   assign rd_hit = s_axi_araddr[ADDR_W-1:2] == MISC_OFS[ADDR_W-1:2];
   assign rvalid_next = ar_hs || (s_axi_rvalid && !s_axi_rready);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= RESP_OKAY;
      end else begin
         s_axi_arready <= !rvalid_next;
         s_axi_rvalid <= rvalid_next;
         if (ar_hs) begin
            s_axi_rdata <= rd_hit ? {24'h00_0000, misc_reg} : 32'h0000_0000;
            s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
         end
      end
   end

   // ======================================================
   // outputs to pin, core and peripherals
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         reset_pin_o <= 1'b0;
         reset_pin_oe <= 1'b1;
         cpu_reset <= 1'b1;
         periph_reset <= 1'b1;
         reset_exit <= 1'b0;
         imask_clear <= 1'b0;
         osc_off <= 1'b1;
         conv_nvm_reset <= 1'b1;
         misc_ctrl <= {1'b1, 3'h1, 3'h0, WD_OPTION};
      end else begin
         // open drain: only ever drives low
         reset_pin_o <= 1'b0;
         reset_pin_oe <= (state_next == ST_POR) || (state_next == ST_WDHOLD)
            || ((state_next == ST_OSC) && por_seq_next); // [R02] [R08] [R14]
         cpu_reset <= in_reset_next; // [R25]
         // timer, direction regs, stack, latches, bus restart, serial port
         periph_reset <= ext_por_next; // [R17] [R18] [R19]
         reset_exit <= in_reset_now && (state_next == ST_RUN); // [R01] [R07]
         imask_clear <= wait_entry || stop_entry; // [R20]
         osc_off <= (state_next == ST_OSC) || (state_next == ST_STOP); // [R21]
         conv_nvm_reset <= ext_por_next || stop_entry || (state_next == ST_STOP); // [R22]
         misc_ctrl <= misc_next;
      end
   end

   // constants the core loads when leaving reset
   always_ff @(posedge aclk) begin
      reset_vector <= RESET_VECTOR; // [R01]
      timer_preset <= TIMER_PRESET; // [R17]
      stack_init <= STACK_INIT; // [R17]
   end
endmodule

// *** test/rwc_checker.sv ***
// assertions on the reset controller ports
`timescale 1ns/1ps
module rwc_checker import rwc_pkg::*; #(parameter logic [11:0] HOLD_CYC = 12'h008) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic reset_pin_i,
   input wire logic reset_pin_oe,
   input wire logic stop_exec,
   input wire logic cpu_reset,
   input wire logic periph_reset,
   input wire logic reset_exit,
   input wire logic [15:0] reset_vector,
   input wire logic [15:0] timer_preset,
   input wire logic [15:0] stack_init,
   input wire logic imask_clear,
   input wire logic osc_off,
   input wire logic conv_nvm_reset,
   input wire logic [7:0] misc_ctrl
);
   // ======================================================
   // helper counters
   logic [15:0] osc_cnt;
   logic [15:0] low_cnt;
   always_ff @(posedge aclk) begin
      osc_cnt <= (!aresetn || !osc_off) ? 16'h0000 : osc_cnt + 16'h0001;
      low_cnt <= (!aresetn || reset_pin_i) ? 16'h0000 : low_cnt + 16'h0001;
   end
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // ======================================================
   // properties
   exit_vector_a: assert property (reset_exit |-> reset_vector == RESET_VECTOR && $past(cpu_reset)
      && !cpu_reset) else $error("bad reset exit");
   exit_single_a: assert property ($fell(cpu_reset) |-> reset_exit)
      else $error("no exit pulse");
   pin_low_stay_a: assert property ((!reset_pin_i) [*6] |-> !reset_exit)
      else $error("exit while pin low");
   periph_vals_a: assert property (periph_reset |-> timer_preset == TIMER_PRESET
      && stack_init == STACK_INIT && conv_nvm_reset && cpu_reset) else $error("bad reset values");
   por_flag_a: assert property (!$rose(misc_ctrl[BIT_POR]))
      else $error("stray power-on flag");
   wd_bit_kept_a: assert property ($fell(misc_ctrl[BIT_WD]) |-> ##[0:2]
      (cpu_reset || $past(cpu_reset) || osc_off)) else $error("enable bit dropped");
   pin_hold_a: assert property ($fell(reset_pin_oe) |-> low_cnt >= 16'(HOLD_CYC))
      else $error("pin hold too short");
   pin_drive_a: assert property ($rose(reset_pin_oe) |-> cpu_reset && !periph_reset)
      else $error("pin driven alone");
   osc_time_a: assert property ($fell(osc_off) |-> osc_cnt >= 16'(OSC_OFF_CYC) - 16'h0004)
      else $error("oscillator early");
   stop_clear_a: assert property (stop_exec && !misc_ctrl[BIT_WD] && !cpu_reset && !osc_off
      |-> ##[0:3] imask_clear) else $error("no mask clear");
   stop_wd_a: assert property (stop_exec && misc_ctrl[BIT_WD] && !cpu_reset
      |-> ##[1:4] (reset_pin_oe && !osc_off)) else $error("stop did not reset");
endmodule
bind rwc_top rwc_checker #(.HOLD_CYC(HOLD_CYC)) u_rwc_checker (.aclk, .aresetn, .reset_pin_i, .reset_pin_oe,
   .stop_exec, .cpu_reset, .periph_reset, .reset_exit, .reset_vector, .timer_preset, .stack_init, .imask_clear,
   .osc_off, .conv_nvm_reset, .misc_ctrl);

// *** test/rwc_pin_model.sv ***
// external reset circuit on the open-drain reset pin, with pull-up
`timescale 1ns/1ps
module rwc_pin_model #(parameter int SLOW_CYC = 5) (
   input wire logic aclk,
   input wire logic reset_pin_o,
   input wire logic reset_pin_oe,
   input wire logic agent_low,
   output logic pin
);
   // ======================================================
   // rc recharge holds the pin low after release
   int cnt = 0;
   always @(posedge aclk) begin
      cnt <= reset_pin_oe ? SLOW_CYC : (cnt > 0 ? cnt - 1 : 0);
   end
   assign pin = ((reset_pin_oe && !reset_pin_o) || agent_low || cnt > 0) ? 1'b0 : 1'b1;
endmodule

// *** test/rwc_top_tb_top.sv ***
// testbench for the reset and watchdog controller
`timescale 1ns/1ps
module rwc_top_tb_top;
   import rwc_pkg::*;
   // ======================================================
   // signals and hookup
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, misc_ctrl;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, reset_pin_o, reset_pin_oe;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic timer_carry7 = 0, cpu_imask = 1, wait_mode = 0, stop_exec = 0, stop_wake = 0, agent_low = 1, carry_en = 0;
   logic cpu_reset, periph_reset, reset_exit, imask_clear, osc_off, conv_nvm_reset;
   logic [15:0] reset_vector, timer_preset, stack_init;
   wire reset_pin_i;
   int fails = 0, total_checks = 0, cyc = 0;
   logic [16:0] tbl [5] = '{17'h10000, 17'h18000, 17'h07000, 17'h17070, 17'h10000};
   always #25 aclk = ~aclk;
   rwc_top #(.STARTUP_LONG(1'b0)) u_rwc_top (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready, .reset_pin_i, .reset_pin_o, .reset_pin_oe, .timer_carry7, .cpu_imask, .wait_mode, .stop_exec,
      .stop_wake, .cpu_reset, .periph_reset, .reset_exit, .reset_vector, .timer_preset, .stack_init, .imask_clear,
      .osc_off, .conv_nvm_reset, .misc_ctrl);
   rwc_pin_model u_rwc_pin_model (.aclk, .reset_pin_o, .reset_pin_oe, .agent_low, .pin(reset_pin_i));
   always @(posedge aclk) timer_carry7 <= carry_en ? ~timer_carry7 : 1'b0;
   always @(posedge aclk) begin
      cyc++;
      if (cyc == 60000) begin
         fails++;
         final_report();
      end
   end
   // ======================================================
   // tasks
   task final_report();
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      total_checks++;
      if (got !== exp) begin
         fails++;
         $display("ERROR %s expected %h seen %h", name, exp, got);
      end
   endtask
   function logic sig(input int sel);
      case (sel)
         0: return reset_pin_oe;
         1: return cpu_reset;
         2: return reset_exit;
         3: return imask_clear;
         default: return osc_off;
      endcase
   endfunction
   // bounded wait for one output to reach a level
   task await(input string name, input int sel, input logic val, input int lim, output int n);
      n = 0;
      while (sig(sel) !== val && n < lim) begin
         @(posedge aclk);
         n++;
      end
      chk(name, 1, n < lim);
   endtask
   task wr(input logic [7:0] a, input logic [7:0] d, output logic [1:0] r);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_awvalid <= 1'b1;
      s_axi_wdata <= {24'h0, d};
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1);
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask
   task rd(input logic [7:0] a, output logic [7:0] d, output logic [1:0] r);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1);
      d = s_axi_rdata[7:0];
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask
   task wmisc(input logic [7:0] d);
      logic [1:0] r;
      wr(MISC_OFS, d, r);
      chk("bresp", RESP_OKAY, r);
   endtask
   task rmisc(input string name, input logic [7:0] mask, input logic [7:0] exp);
      logic [7:0] d;
      logic [1:0] r;
      rd(MISC_OFS, d, r);
      chk(name, exp, d & mask);
      chk("rresp", RESP_OKAY, r);
   endtask
   // ======================================================
   // test sequence
   initial begin
      int n;
      logic [7:0] d;
      logic [1:0] r;
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      await("startup", 0, 1'b0, 4200, n);
      chk("startup_len", 1, n >= 4080 && n <= 4083);
      repeat (20) @(posedge aclk);
      chk("held_by_pin", 1, cpu_reset);
      rmisc("misc_por", 8'hFF, 8'h90);
      agent_low <= 1'b0;
      await("por_exit", 2, 1'b1, 8, n);
      chk("vector", RESET_VECTOR, reset_vector);
      $display("test power_on done");
      for (int i = 0; i < 5; i++) begin
         cpu_imask <= tbl[i][16];
         wmisc(tbl[i][15:8]);
         rmisc("misc_write", 8'hFF, tbl[i][7:0]);
      end
      rd(8'h20, d, r);
      chk("unmapped_rresp", RESP_SLVERR, r);
      wr(8'h20, 8'hFF, r);
      chk("unmapped_bresp", RESP_SLVERR, r);
      rmisc("misc_kept", 8'hFF, 8'h00);
      $display("test registers done");
      agent_low <= 1'b1;
      @(posedge aclk);
      agent_low <= 1'b0;
      repeat (8) @(posedge aclk);
      chk("glitch", 0, cpu_reset);
      agent_low <= 1'b1;
      await("ext_entry", 1, 1'b1, 8, n);
      chk("periph", 1, periph_reset);
      chk("ext_no_drive", 0, reset_pin_oe);
      repeat (4) @(posedge aclk);
      agent_low <= 1'b0;
      await("ext_exit", 2, 1'b1, 8, n);
      rmisc("misc_ext", 8'hFF, 8'h10);
      $display("test external done");
      wmisc(8'h01);
      wmisc(8'h00);
      rmisc("wd_on", 8'h01, 8'h01);
      carry_en <= 1'b1;
      repeat (10240) @(posedge aclk);
      chk("wd_early", 0, cpu_reset);
      wmisc(8'h01);
      repeat (10240) @(posedge aclk);
      chk("wd_cleared", 0, cpu_reset);
      await("wd_fire", 0, 1'b1, 4400, n);
      chk("wd_reset", 1, cpu_reset);
      await("wd_exit", 2, 1'b1, 100, n);
      rmisc("wd_after", 8'h81, 8'h00);
      carry_en <= 1'b0;
      $display("test watchdog done");
      wait_mode <= 1'b1;
      await("wait_mask", 3, 1'b1, 6, n);
      wait_mode <= 1'b0;
      wmisc(8'h02);
      stop_exec <= 1'b1;
      @(posedge aclk);
      stop_exec <= 1'b0;
      await("stop_mask", 3, 1'b1, 6, n);
      repeat (2) @(posedge aclk);
      chk("stop_osc", 1, osc_off);
      stop_wake <= 1'b1;
      @(posedge aclk);
      stop_wake <= 1'b0;
      repeat (4000) @(posedge aclk);
      chk("osc_hold", 1, osc_off);
      await("osc_on", 4, 1'b0, 200, n);
      chk("stop_no_reset", 0, cpu_reset);
      rmisc("stop_slow", 8'h02, 8'h00);
      wmisc(8'h01);
      stop_exec <= 1'b1;
      @(posedge aclk);
      stop_exec <= 1'b0;
      await("stop_wd", 0, 1'b1, 8, n);
      chk("stop_wd_osc", 0, osc_off);
      await("stop_wd_exit", 2, 1'b1, 100, n);
      $display("test stop_wait done");
      final_report();
   end
endmodule
